// file: logic/dia_unit.sv
// digital input function unit: filtering, actions, counters and wishbone registers
//
// Function
// (R1) Two inputs, 0.0 and 0.1, each with its own action setting.
// (R2) Action none ignores the input; none is the reset default.
// (R3) Write-lock action: active input level blocks settings writes.
// (R4) Pulse action counts pulses arriving on the input.
// (R5) Tariff action: low tariff while active, high while inactive.
// (R6) Minute-sync pulse snaps internal clock to minute within thirty seconds.
// (R7) Minute-sync: event when twenty minutes pass without a pulse.
// (R8) Sync correction held while date/time screen is open.
// (R9) Demand-sync action marks demand period boundaries.
// (R10) Status action: one event per input transition.
// (R11) Start/stop: targets run while active, halt while inactive.
// (R12) Copy-and-clear: on rising input copy targets then clear them.
// (R13) Reset action clears targets on each rising input.
// (R14) Mode picks whole pulses or single edges; pulses default.
// (R15) Counter steps once per configured pulses, 1 to 999, default 1.
// (R16) Counted unit: active, reactive energy or user text unit.
// (R17) Pulse targets and process-and-pulse accept only reset.
// (R18) All-process target takes all three; single process not start/stop.
// (R19) Linked user counter shown whatever action, only with expansion fitted.
// (R20) Inputs synchronised and debounced before level or edge use.
// (R21) Source holds each level long enough to pass the filter.
`timescale 1ns/1ps
`default_nettype none
module dia_unit #(
  parameter int SEC_CYCLES = dia_pkg::SEC_CYCLES,
  parameter int DEBOUNCE_CYCLES = dia_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // field inputs and system status
  input wire logic [1:0] din,
  input wire logic expansion_present,
  // functions
  output logic settings_locked,
  output logic tariff_low,
  output logic demand_sync,
  output logic minute_advance,
  output logic [5:0] clock_sec,
  output logic [1:0] status_event,
  output logic [1:0] sync_lost_event,
  output logic [1:0] count_step,
  output dia_pkg::dia_ctr_t [1:0] ctr_ctl
);
  // ==========================================================
  // functions
  function automatic logic [9:0] clamp_ppu(input logic [9:0] v);
    if (v < dia_pkg::PPU_MIN) begin
      return dia_pkg::PPU_MIN;
    end else if (v > dia_pkg::PPU_MAX) begin
      return dia_pkg::PPU_MAX;
    end
    return v;
  endfunction : clamp_ppu

  // target/action legality table
  function automatic logic tgt_ok(input dia_pkg::dia_action_t a, input dia_pkg::dia_target_t t);
    case (t)
      dia_pkg::TGT_PROC_ALL: tgt_ok = 1'b1; // R18
      dia_pkg::TGT_PROC_ONE: tgt_ok = (a != dia_pkg::ACT_STARTSTOP); // R18
      dia_pkg::TGT_PROC_PULSE, dia_pkg::TGT_PULSE_ALL, dia_pkg::TGT_PULSE_ONE: begin
        tgt_ok = (a == dia_pkg::ACT_RESET); // R17
      end
      default: tgt_ok = 1'b0;
    endcase
  endfunction : tgt_ok

  // ==========================================================
  // state
  dia_pkg::dia_cfg_t [1:0] cfg_q, cfg_d;
  logic dt_edit_q, dt_edit_d;
  logic [5:0] evt_q, evt_d;
  logic [1:0] s1_q, s2_q, filt_q, filt_d, prev_q, prev_d;
  logic [15:0] deb_q [2];
  logic [15:0] deb_d [2];
  logic [9:0] pre_q [2];
  logic [9:0] pre_d [2];
  logic [31:0] cnt_q [2];
  logic [31:0] cnt_d [2];
  logic [10:0] miss_q [2];
  logic [10:0] miss_d [2];
  logic [24:0] sub_q, sub_d;
  logic [5:0] sec_q, sec_d;
  logic pend_q, pend_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic lock_q, lock_d, tariff_q, tariff_d, dsync_q, dsync_d, madv_q, madv_d;
  logic [1:0] stev_q, stev_d, lost_q, lost_d, step_q, step_d;
  dia_pkg::dia_ctr_t [1:0] ctl_q, ctl_d;
  logic [1:0] rise, fall;
  logic sec_tick, sync_pulse, wr, rd;

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign rise = filt_q & ~prev_q;
  assign fall = ~filt_q & prev_q;
  assign sec_tick = (sub_q == 25'(SEC_CYCLES - 1));

  // ==========================================================
  // input conditioning
  always_comb begin
    for (int i = 0; i < dia_pkg::NUM_IN; i++) begin
      filt_d[i] = filt_q[i];
      deb_d[i] = 16'h0000;
      // bounce restarts the count; a level must hold the full window
      if (s2_q[i] != filt_q[i]) begin // R20
        if (deb_q[i] == 16'(DEBOUNCE_CYCLES - 1)) begin
          filt_d[i] = s2_q[i];
        end else begin
          deb_d[i] = deb_q[i] + 16'h0001;
        end
      end
    end
    prev_d = filt_q;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      filt_q <= 2'h0;
      prev_q <= 2'h0;
      deb_q <= '{16'h0000, 16'h0000};
    end else begin
      s1_q <= din; // R20
      s2_q <= s1_q;
      filt_q <= filt_d;
      prev_q <= prev_d;
      deb_q <= deb_d;
    end
  end

  // ==========================================================
  // actions
  always_comb begin
    lock_d = 1'b0;
    tariff_d = 1'b0;
    dsync_d = 1'b0;
    stev_d = 2'h0;
    step_d = 2'h0;
    sync_pulse = 1'b0;
    for (int i = 0; i < dia_pkg::NUM_IN; i++) begin
      pre_d[i] = pre_q[i];
      cnt_d[i] = cnt_q[i];
      ctl_d[i].target = cfg_q[i].target;
      ctl_d[i].idx = cfg_q[i].idx;
      ctl_d[i].run = 1'b0;
      ctl_d[i].copy = 1'b0;
      ctl_d[i].clear = 1'b0;
      case (cfg_q[i].action) // R1 R2
        dia_pkg::ACT_WLOCK: lock_d = lock_d | filt_q[i]; // R3
        dia_pkg::ACT_TARIFF: tariff_d = tariff_d | filt_q[i]; // R5
        dia_pkg::ACT_DSYNC: dsync_d = dsync_d | rise[i]; // R9
        dia_pkg::ACT_TSYNC: sync_pulse = sync_pulse | rise[i]; // R6
        dia_pkg::ACT_STATUS: stev_d[i] = rise[i] | fall[i]; // R10
        dia_pkg::ACT_PULSE: begin
          // edge mode counts both edges, pulse mode one per pulse
          if (rise[i] | (cfg_q[i].edge_mode & fall[i])) begin // R4 R14
            if (pre_q[i] >= clamp_ppu(cfg_q[i].ppu) - 10'h001) begin // R15
              pre_d[i] = 10'h000;
              cnt_d[i] = cnt_q[i] + 32'h0000_0001;
              step_d[i] = 1'b1;
            end else begin
              pre_d[i] = pre_q[i] + 10'h001;
            end
          end
        end
        dia_pkg::ACT_STARTSTOP: begin
          ctl_d[i].run = filt_q[i] & tgt_ok(cfg_q[i].action, cfg_q[i].target); // R11
        end
        dia_pkg::ACT_COPYCLR: begin
          // copy this cycle, clear the next: copy always sees old counts
          ctl_d[i].copy = rise[i] & tgt_ok(cfg_q[i].action, cfg_q[i].target); // R12
          ctl_d[i].clear = ctl_q[i].copy; // R12
        end
        dia_pkg::ACT_RESET: begin
          ctl_d[i].clear = rise[i] & tgt_ok(cfg_q[i].action, cfg_q[i].target); // R13
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // minute clock and sync supervision
  always_comb begin
    sub_d = sec_tick ? 25'h0 : sub_q + 25'h1;
    sec_d = sec_q;
    madv_d = 1'b0;
    pend_d = pend_q | sync_pulse;
    if (sec_tick) begin
      sec_d = (sec_q == dia_pkg::SEC_PER_MIN - 6'h01) ? 6'h00 : sec_q + 6'h01;
    end
    // a full minute is at most thirty seconds off either way
    if (pend_q && !dt_edit_q) begin // R8
      sub_d = 25'h0;
      sec_d = 6'h00;
      madv_d = (sec_q >= 6'(dia_pkg::SYNC_MAX_DEV_S)); // R6
      pend_d = sync_pulse;
    end
    lost_d = 2'h0;
    for (int i = 0; i < dia_pkg::NUM_IN; i++) begin
      miss_d[i] = miss_q[i];
      if (cfg_q[i].action != dia_pkg::ACT_TSYNC || rise[i]) begin
        miss_d[i] = 11'h000;
      end else if (sec_tick) begin
        if (miss_q[i] == 11'(dia_pkg::SYNC_MISS_S - 1)) begin // R7
          miss_d[i] = 11'h000;
          lost_d[i] = 1'b1;
        end else begin
          miss_d[i] = miss_q[i] + 11'h001;
        end
      end
    end
  end

  // ==========================================================
  // wishbone registers
  always_comb begin
    cfg_d = cfg_q;
    dt_edit_d = dt_edit_q;
    evt_d = evt_q;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = rdat_q;
    // settings only change while no lock input is active
    if (wr && !lock_q) begin // R3
      if (wb_adr_i == dia_pkg::OFS_CFG0 || wb_adr_i == dia_pkg::OFS_CFG1) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            cfg_d[wb_adr_i[2]][8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        // spare bits always read back as zero
        cfg_d[wb_adr_i[2]].spare_hi = 6'h00;
        cfg_d[wb_adr_i[2]].spare_lo = 2'h0;
      end else if (wb_adr_i == dia_pkg::OFS_CTRL && wb_sel_i[0]) begin
        dt_edit_d = wb_dat_i[0];
      end
    end
    if (wr && wb_adr_i == dia_pkg::OFS_EVT && wb_sel_i[0]) begin
      evt_d = evt_q & ~wb_dat_i[5:0];
    end
    // hardware set wins over a same-cycle clear
    evt_d[dia_pkg::EVT_STATUS_LSB +: 2] = evt_d[dia_pkg::EVT_STATUS_LSB +: 2] | stev_q; // R10
    evt_d[dia_pkg::EVT_MISS_LSB +: 2] = evt_d[dia_pkg::EVT_MISS_LSB +: 2] | lost_q; // R7
    for (int i = 0; i < dia_pkg::NUM_IN; i++) begin
      evt_d[dia_pkg::EVT_SYNC_LSB + i] = evt_d[dia_pkg::EVT_SYNC_LSB + i] |
        (pend_q & ~dt_edit_q & (cfg_q[i].action == dia_pkg::ACT_TSYNC));
    end
    if (rd) begin
      if (wb_adr_i == dia_pkg::OFS_CFG0) begin
        rdat_d = 32'(cfg_q[0]);
      end else if (wb_adr_i == dia_pkg::OFS_CFG1) begin
        rdat_d = 32'(cfg_q[1]);
      end else if (wb_adr_i == dia_pkg::OFS_CTRL) begin
        rdat_d = {31'h0, dt_edit_q};
      end else if (wb_adr_i == dia_pkg::OFS_EVT) begin
        rdat_d = {26'h0, evt_q};
      end else if (wb_adr_i == dia_pkg::OFS_CNT0) begin
        rdat_d = expansion_present ? cnt_q[0] : 32'h0; // R19
      end else if (wb_adr_i == dia_pkg::OFS_CNT1) begin
        rdat_d = expansion_present ? cnt_q[1] : 32'h0; // R19
      end else if (wb_adr_i == dia_pkg::OFS_STAT) begin
        rdat_d = {16'h0, pend_q, lock_q, filt_q, 6'h0, sec_q};
      end else begin
        rdat_d = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= {dia_pkg::CFG_RESET, dia_pkg::CFG_RESET}; // R2 R14 R15 R16
      dt_edit_q <= 1'b0;
      evt_q <= 6'h00;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      pre_q <= '{10'h000, 10'h000};
      cnt_q <= '{32'h0, 32'h0};
      miss_q <= '{11'h000, 11'h000};
      sub_q <= 25'h0;
      sec_q <= 6'h00;
      pend_q <= 1'b0;
      lock_q <= 1'b0;
      tariff_q <= 1'b0;
      dsync_q <= 1'b0;
      madv_q <= 1'b0;
      stev_q <= 2'h0;
      lost_q <= 2'h0;
      step_q <= 2'h0;
      ctl_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      dt_edit_q <= dt_edit_d;
      evt_q <= evt_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      miss_q <= miss_d;
      sub_q <= sub_d;
      sec_q <= sec_d;
      pend_q <= pend_d;
      lock_q <= lock_d;
      tariff_q <= tariff_d;
      dsync_q <= dsync_d;
      madv_q <= madv_d;
      stev_q <= stev_d;
      lost_q <= lost_d;
      step_q <= step_d;
      ctl_q <= ctl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign settings_locked = lock_q;
  assign tariff_low = tariff_q;
  assign demand_sync = dsync_q;
  assign minute_advance = madv_q;
  assign clock_sec = sec_q;
  assign status_event = stev_q;
  assign sync_lost_event = lost_q;
  assign count_step = step_q;
  assign ctr_ctl = ctl_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  AST_NONE_IGNORED: assert property ((cfg_q[0].action == dia_pkg::ACT_NONE && $stable(cfg_q[0]))
    |=> (!status_event[0] && !count_step[0] && !ctr_ctl[0].clear)) // R2
    else $error("idle input had an effect");
  AST_LOCK_FOLLOWS: assert property ((cfg_q[0].action == dia_pkg::ACT_WLOCK && filt_q[0])
    |=> settings_locked) // R3
    else $error("lock not raised");
  AST_LOCK_BLOCKS: assert property ((lock_q && wb_cyc_i && wb_stb_i && wb_we_i && !ack_q
    && wb_adr_i == dia_pkg::OFS_CFG0) |=> $stable(cfg_q[0])) // R3
    else $error("config written while locked");
  AST_TARIFF: assert property ((cfg_q[1].action == dia_pkg::ACT_TARIFF && filt_q[1]) |=> tariff_low) // R5
    else $error("tariff not low");
  AST_STATUS_EDGE: assert property ((cfg_q[0].action == dia_pkg::ACT_STATUS && filt_q[0] != prev_q[0])
    |=> status_event[0] ##1 !status_event[0]) // R10
    else $error("status event missing or repeated");
  AST_STATUS_STICKY: assert property (status_event[1] |=> evt_q[dia_pkg::EVT_STATUS_LSB + 1]) // R10
    else $error("status event lost");
  AST_HOLD_EDIT: assert property ((pend_q && dt_edit_q) |=> pend_q) // R8
    else $error("sync applied during edit");
  AST_APPLY: assert property ((pend_q && !dt_edit_q) |=> (sec_q == 6'h00 && sub_q == 25'h0)) // R6
    else $error("sync not applied");
  AST_STARTSTOP_PROC_ONE: assert property (cfg_q[0].action == dia_pkg::ACT_STARTSTOP
    && cfg_q[0].target == dia_pkg::TGT_PROC_ONE |=> !ctr_ctl[0].run) // R18
    else $error("illegal start/stop target ran");
  AST_RESET_ONLY: assert property (ctr_ctl[0].copy |-> ctr_ctl[0].target inside
    {dia_pkg::TGT_PROC_ALL, dia_pkg::TGT_PROC_ONE}) // R17
    else $error("copy on pulse target");
  AST_COPY_THEN_CLEAR: assert property ($rose(ctr_ctl[0].copy) && cfg_q[0].action == dia_pkg::ACT_COPYCLR
    |=> ctr_ctl[0].clear) // R12
    else $error("clear did not follow copy");
  AST_FILTER: assert property ((s2_q[0] != filt_q[0]) && (deb_q[0] == 16'h0000)
    |=> filt_q[0] == $past(filt_q[0])) // R20
    else $error("filter passed a one-cycle change");
  AST_PPU_STEP: assert property (count_step[0] |-> cnt_q[0] == $past(cnt_q[0]) + 32'h1) // R15
    else $error("counter step mismatch");

  COV_PULSE_STEP: cover property (count_step[0]);
  COV_SYNC_APPLIED: cover property (pend_q && !dt_edit_q);
  COV_SYNC_LOST: cover property (sync_lost_event[1]);
  COV_COPY_CLEAR: cover property (ctr_ctl[0].copy ##1 ctr_ctl[0].clear);
endmodule : dia_unit
`default_nettype wire

// file: include/dia_pkg.sv
// package: constants, types and register map of the digital input function unit
package dia_pkg;
  // ==========================================================
  // inputs and timing
  localparam int NUM_IN = 2;
  localparam int CLK_HZ = 25000000;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int SYNC_MAX_DEV_S = 30;
  localparam int SYNC_MISS_MIN = 20;
  localparam int SYNC_MISS_S = SYNC_MISS_MIN * 60;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_EVT = 8'h0c;
  localparam logic [7:0] OFS_CNT0 = 8'h10;
  localparam logic [7:0] OFS_CNT1 = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // ==========================================================
  // field positions
  localparam int CFG_MODE_BIT = 4;
  localparam int CFG_UNIT_LSB = 5;
  localparam int CFG_TGT_LSB = 7;
  localparam int CFG_IDX_LSB = 10;
  localparam int CFG_PPU_LSB = 16;
  localparam int EVT_STATUS_LSB = 0;
  localparam int EVT_MISS_LSB = 2;
  localparam int EVT_SYNC_LSB = 4;
  localparam logic [9:0] PPU_MIN = 10'h001;
  localparam logic [9:0] PPU_MAX = 10'h3e7;
  localparam logic [31:0] CFG_RESET = 32'h0001_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ACT_NONE = 4'h0, ACT_WLOCK = 4'h1, ACT_PULSE = 4'h2, ACT_TARIFF = 4'h3,
    ACT_TSYNC = 4'h4, ACT_DSYNC = 4'h5, ACT_STATUS = 4'h6, ACT_STARTSTOP = 4'h7,
    ACT_COPYCLR = 4'h8, ACT_RESET = 4'h9
  } dia_action_t;
  typedef enum logic [2:0] {
    TGT_PROC_PULSE = 3'h0, TGT_PULSE_ALL = 3'h1, TGT_PULSE_ONE = 3'h2,
    TGT_PROC_ALL = 3'h3, TGT_PROC_ONE = 3'h4
  } dia_target_t;
  typedef enum logic [1:0] {
    UNIT_KWH = 2'h0, UNIT_KVARH = 2'h1, UNIT_TEXT = 2'h2
  } dia_unit_t;
  // spare fields pad the word so ppu sits at CFG_PPU_LSB and byte lanes stay in range
  typedef struct packed {
    logic [5:0] spare_hi;
    logic [9:0] ppu;
    logic [1:0] spare_lo;
    logic [3:0] idx;
    dia_target_t target;
    dia_unit_t unit;
    logic edge_mode;
    dia_action_t action;
  } dia_cfg_t;
  typedef struct packed {
    logic run;
    logic copy;
    logic clear;
    dia_target_t target;
    logic [3:0] idx;
  } dia_ctr_t;
endpackage : dia_pkg

// file: tb/dia_contact.sv
// bench model of a field contact or pulse meter driving one input
`timescale 1ns/1ps
`default_nettype none
module dia_contact (
  // clock
  input wire logic sys_clk,
  // requested level and bounce enable
  input wire logic lvl,
  input wire logic bouncy,
  // line to the device
  output logic line
);
  logic last;
  int bnc;
  initial begin
    line = 1'b0;
    last = 1'b0;
    bnc = 0;
  end
  // ==========================================================
  // contact bounce: one-cycle glitches, then the level stands
  always @(posedge sys_clk) begin
    if (lvl !== last) begin
      last <= lvl;
      line <= lvl;
      bnc <= bouncy ? 4 : 0;
    end else if (bnc > 0) begin
      bnc <= bnc - 1;
      line <= (bnc == 1) ? last : ~line;
    end
  end
  // the bench keeps every level far longer than the filter window
endmodule : dia_contact
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the digital input function unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SECC = 20;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, exp_on = 1'b1, bouncy = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, r;
  logic [1:0] lv = 2'h0, din_w;
  logic ack, locked, tlow, dsync, madv;
  logic [5:0] sec;
  logic [1:0] stev, lost, step;
  dia_pkg::dia_ctr_t [1:0] ctl;
  logic [11:0] ev;
  logic [11:0] notes[$];
  int n_fail = 0, n_checks = 0, seed = 83763, p, a, t;
  logic run, cp, cl;
  always #20 sys_clk = ~sys_clk;
  dia_unit #(.SEC_CYCLES(SECC), .DEBOUNCE_CYCLES(3)) i_dia_unit (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .din(din_w), .expansion_present(exp_on), .settings_locked(locked),
    .tariff_low(tlow), .demand_sync(dsync), .minute_advance(madv), .clock_sec(sec), .status_event(stev),
    .sync_lost_event(lost), .count_step(step), .ctr_ctl(ctl));
  dia_contact i_dia_contact0 (.sys_clk(sys_clk), .lvl(lv[0]), .bouncy(bouncy), .line(din_w[0]));
  dia_contact i_dia_contact1 (.sys_clk(sys_clk), .lvl(lv[1]), .bouncy(bouncy), .line(din_w[1]));
  assign ev = {madv, lost, ctl[1].copy, ctl[1].clear, ctl[0].copy, ctl[0].clear, dsync, stev, step};
  // ==========================================================
  // compare and close
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // wishbone classic master, waits on ack with a bound
  task automatic wb(input logic w, input logic [7:0] a_i, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a_i;
    dat <= d;
    // reads ignore the lanes, so they get random ones
    sel <= w ? 4'hf : 4'($random(seed));
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (k >= 50) n_fail++;
  endtask : wb
  task automatic wr(input logic [7:0] a_i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a_i, d, q);
  endtask : wr
  // ==========================================================
  // field input helpers
  task automatic set_in(input int i, input logic l);
    lv[i] <= l;
    repeat (20) @(posedge sys_clk);
  endtask : set_in
  task automatic pulse_in(input int i);
    set_in(i, 1'b1);
    set_in(i, 1'b0);
  endtask : pulse_in
  task automatic wait_sec(input logic [5:0] s);
    int k;
    k = 0;
    while (sec !== s && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 3000) n_fail++;
  endtask : wait_sec
  // ==========================================================
  // monitor: each event pulse takes the oldest note
  always @(posedge sys_clk) begin
    if (!sys_rst && ev !== 12'h000) begin
      if (notes.size() == 0) check("events", 32'(ev), 32'h0);
      else check("events", 32'(ev), 32'(notes.pop_front()));
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wb(1'b0, dia_pkg::OFS_CFG0, 32'h0, r);
    check("cfg0", r, dia_pkg::CFG_RESET);
    wb(1'b0, 8'h20, 32'h0, r);
    check("unmapped", r, 32'h0);
    pulse_in(0);
    pulse_in(1);
    $display("test reset and idle done");
    wr(dia_pkg::OFS_CFG0, 32'h0001_0002);
    repeat (2) notes.push_back(12'h001);
    repeat (2) pulse_in(0);
    wr(dia_pkg::OFS_CFG0, 32'h0001_0012);
    repeat (4) notes.push_back(12'h001);
    repeat (2) pulse_in(0);
    p = 2 + ({$random(seed)} % 4);
    wr(dia_pkg::OFS_CFG0, (32'(p) << dia_pkg::CFG_PPU_LSB) | 32'h42);
    wb(1'b0, dia_pkg::OFS_CFG0, 32'h0, r);
    check("cfg0 unit", r, (32'(p) << dia_pkg::CFG_PPU_LSB) | 32'h42);
    repeat (2) notes.push_back(12'h001);
    repeat (2 * p) pulse_in(0);
    wr(dia_pkg::OFS_CFG0, 32'h0001_0000);
    wb(1'b0, dia_pkg::OFS_CNT0, 32'h0, r);
    check("cnt0", r, 32'h0000_0008);
    exp_on <= 1'b0;
    wb(1'b0, dia_pkg::OFS_CNT0, 32'h0, r);
    check("cnt0 bare", r, 32'h0);
    exp_on <= 1'b1;
    $display("test pulse counting done");
    wr(dia_pkg::OFS_CFG0, 32'h0001_0001);
    set_in(0, 1'b1);
    check("locked", 32'(locked), 32'h1);
    wr(dia_pkg::OFS_CFG1, 32'h0001_0006);
    wb(1'b0, dia_pkg::OFS_CFG1, 32'h0, r);
    check("cfg1 locked", r, dia_pkg::CFG_RESET);
    set_in(0, 1'b0);
    check("unlocked", 32'(locked), 32'h0);
    wr(dia_pkg::OFS_CFG1, 32'h0001_0003);
    set_in(1, 1'b1);
    check("tariff", 32'(tlow), 32'h1);
    set_in(1, 1'b0);
    check("tariff", 32'(tlow), 32'h0);
    wr(dia_pkg::OFS_CFG1, 32'h0001_0006);
    repeat (2) notes.push_back(12'h008);
    pulse_in(1);
    wr(dia_pkg::OFS_CFG1, 32'h0001_0005);
    notes.push_back(12'h010);
    pulse_in(1);
    wr(dia_pkg::OFS_CFG1, 32'h0001_0000);
    $display("test level actions done");
    bouncy <= 1'b0;
    for (a = 7; a <= 9; a++) begin
      for (t = 0; t <= 4; t++) begin
        cp = (a == 8 && t >= 3);
        cl = (a == 9) || cp;
        run = (a == 7 && t == 3);
        wr(dia_pkg::OFS_CFG0, 32'h0001_0000 | 32'(a) | (32'(t) << dia_pkg::CFG_TGT_LSB));
        if (cp) notes.push_back(12'h040);
        if (cl) notes.push_back(12'h020);
        set_in(0, 1'b1);
        check("run", 32'(ctl[0].run), 32'(run));
        set_in(0, 1'b0);
        check("run off", 32'(ctl[0].run), 32'h0);
      end
    end
    bouncy <= 1'b1;
    $display("test counter targets done");
    wr(dia_pkg::OFS_CFG0, 32'h0001_0004);
    wait_sec(6'h0a);
    set_in(0, 1'b1);
    check("sec snap", 32'(sec <= 6'h01), 32'h1);
    set_in(0, 1'b0);
    wait_sec(6'h28);
    notes.push_back(12'h800);
    pulse_in(0);
    wr(dia_pkg::OFS_EVT, 32'h0000_003f);
    wr(dia_pkg::OFS_CTRL, 32'h0000_0001);
    wait_sec(6'h03);
    set_in(0, 1'b1);
    wait_sec(6'h08);
    wb(1'b0, dia_pkg::OFS_EVT, 32'h0, r);
    check("held", r & 32'h30, 32'h0);
    wr(dia_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    check("sec applied", 32'(sec <= 6'h01), 32'h1);
    wb(1'b0, dia_pkg::OFS_EVT, 32'h0, r);
    check("applied", r & 32'h30, 32'h10);
    set_in(0, 1'b0);
    notes.push_back(12'h200);
    repeat (1200 * SECC + 200) @(posedge sys_clk);
    wb(1'b0, dia_pkg::OFS_EVT, 32'h0, r);
    check("sync lost", r & 32'h0c, 32'h04);
    wr(dia_pkg::OFS_CFG0, 32'h0001_0000);
    $display("test time sync done");
    repeat (5) @(posedge sys_clk);
    check("notes left", 32'(notes.size()), 32'h0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
